// >>> hdl/serial_mode_ctrl.v
// Operating-mode controller of a wireless serial-port module: boot load, modes, dialing.
// Assumes an APB master on core_clk, a UART core supplying received bytes and an
// async rx line level, and a radio link layer that reports connects and dial results.
// Notes on behaviour
// RQ1: Host holds resets low 2ms after power; the bench holds rst_n low for only 20 cycles.
// RQ2: Load stored parameters before serving host.
// RQ3: Auto, no peers: connectable, discoverable, full commands.
// RQ4: Auto peer connect: port event, then transparent.
// RQ5: Auto with peers: dial each three times, report.
// RQ6: Command mode skips stored peer list.
// RQ7: Command mode: connect never enters transparent.
// RQ8: Transparent: forward every byte, no command parsing.
// RQ9: Transparent only with exactly one link.
// RQ10: Line break leaves transparent mode.
// RQ11: Force master: accept only with role switch.
// RQ12: Force master first link follows auto/command.
// RQ13: Further links accepted only outside transparent.
// RQ14: Up to three stored peers, auto or on demand.
// RQ15: Event filter: none, standard, or all.
// RQ16: Per-link policy, default all four allowed.
// RQ17: UART speed defaults to 9600 baud.
// RQ18: Framing defaults one stop, no parity.
// RQ19: Mode defaults automatic, zero stored peers.
// RQ20: Link supervision timeout defaults 20 seconds.
// RQ21: Port mask default opens lowest port.
// RQ22: Scan defaults connectable, discoverable; limited option.
// RQ23: Packets framed by 0x02 start, 0x03 end.
// RQ24: Rx low beyond one frame is break.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mode_ctrl_map.vh"

module serial_mode_ctrl #(
  parameter LOAD_CYCLES = 16,
  parameter BREAK_BITS  = 11
) (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        uartRx,
  input  wire        rxValid,
  input  wire [7:0]  rxByte,
  output reg         linkTxValid,
  output reg  [7:0]  linkTxByte,
  output reg         cmdValid,
  output reg  [7:0]  cmdByte,
  output reg         cmdFrameStart,
  output reg         cmdFrameEnd,
  input  wire        peerConnect,
  input  wire        peerRoleSwitchOk,
  input  wire [7:0]  peerPort,
  output reg         acceptLink,
  output reg         rejectLink,
  output reg         dialReq,
  output reg  [1:0]  dialIndex,
  input  wire        dialDone,
  input  wire        dialOk,
  input  wire        phyChange,
  output reg         eventValid,
  output reg  [3:0]  eventCode,
  output reg  [7:0]  eventArg,
  output reg         connectable,
  output reg         discoverable,
  output reg         limitedDiscover,
  output reg         ready,
  output reg         transparent,
  output reg         isMaster
);

  // Event codes to the host
  localparam [3:0] EV_PORT_CONN = 4'h1;
  localparam [3:0] EV_LINK_STAT = 4'h2;
  localparam [3:0] EV_PHY       = 4'h3;
  localparam [3:0] EV_BOOT      = 4'h4;

  localparam [2:0] ST_LOAD  = 3'd0;
  localparam [2:0] ST_DIAL  = 3'd1;
  localparam [2:0] ST_WAIT  = 3'd2;
  localparam [2:0] ST_IDLE  = 3'd3;

  // Stored parameter set, stands in for the non-volatile area
  reg [31:0] param;
  reg [3:0]  policy;
  reg [23:0] baud;
  reg [1:0]  framing;
  reg [7:0]  timeoutSec;
  reg [3:0]  linkCount;
  reg [7:0]  lastRx;

  reg [2:0]  state;
  reg [15:0] loadCnt;
  reg [1:0]  peerIdx;
  reg [1:0]  tries;
  reg        onDemand;
  reg [1:0]  demandIdx;

  wire       cmdMode    = param[`P_CMD_MODE];
  wire       forceMast  = param[`P_FORCE_MASTER];
  wire [1:0] filter     = param[`P_FILTER_HI:`P_FILTER_LO];
  wire [1:0] defCount   = param[`P_DEFCNT_HI:`P_DEFCNT_LO];
  wire [7:0] portMask   = param[`P_PORTS_HI:`P_PORTS_LO];

  // Rx line synchroniser
  reg rxMeta;
  reg rxSync;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
    end else begin
      rxMeta <= uartRx;
      rxSync <= rxMeta;
    end
  end

  // Break: low longer than one frame at the current rate
  wire [31:0] bitCycles = `CLK_HZ / ((baud == 24'h0) ? 32'd1 : {8'h0, baud});
  wire [31:0] frameCyc  = bitCycles * BREAK_BITS;
  reg  [31:0] lowCnt;
  reg         breakSeen;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt    <= 32'h0000_0000;
      breakSeen <= 1'b0;
    end else if (rxSync) begin
      lowCnt    <= 32'h0000_0000;
      breakSeen <= 1'b0;
    end else if (lowCnt <= frameCyc) begin
      lowCnt    <= lowCnt + 32'd1;
    end else begin
      breakSeen <= 1'b1;                                   // see RQ24
    end
  end
  reg breakPrev;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) breakPrev <= 1'b0;
    else breakPrev <= breakSeen;
  end
  wire breakEdge = breakSeen & ~breakPrev;

  // APB slave, zero wait states
  wire apbWr = psel & penable & pwrite;
  wire apbRd = psel & penable & ~pwrite;
  wire hit   = (paddr == `REG_CTRL) || (paddr == `REG_PARAM) || (paddr == `REG_POLICY) ||
               (paddr == `REG_PEER_CMD) || (paddr == `REG_STATUS) ||
               (paddr == `REG_LINK_EVT) || (paddr == `REG_UART_CFG) ||
               (paddr == `REG_TIMEOUT) || (paddr == `REG_RX_DATA);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  wire wrParam  = apbWr && (paddr == `REG_PARAM);
  wire wrPolicy = apbWr && (paddr == `REG_POLICY);
  wire wrUart   = apbWr && (paddr == `REG_UART_CFG);
  wire wrTmo    = apbWr && (paddr == `REG_TIMEOUT);
  wire wrPeer   = apbWr && (paddr == `REG_PEER_CMD);
  wire wrCtrl   = apbWr && (paddr == `REG_CTRL);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      param      <= `PARAM_RESET;                          // see RQ19
      policy     <= `POLICY_RESET;                         // see RQ16
      baud       <= `BAUD_RESET;                           // see RQ17
      framing    <= `FRAMING_RESET;                        // see RQ18
      timeoutSec <= `TIMEOUT_S_RESET;                      // see RQ20
    end else begin
      if (wrParam) param <= pwdata;
      if (wrPolicy) policy <= pwdata[3:0];
      if (wrUart) begin
        baud    <= pwdata[23:0];
        framing <= pwdata[25:24];
      end
      if (wrTmo) timeoutSec <= pwdata[7:0];
    end
  end

  always @* begin
    prdata = 32'h0000_0000;
    if (apbRd) begin
      if (paddr == `REG_PARAM) prdata = param;
      else if (paddr == `REG_POLICY) prdata = {28'h0, policy};
      else if (paddr == `REG_STATUS)
        prdata = {16'h0, linkCount, 1'b0, state, 4'h0, isMaster, transparent, 1'b0, ready};
      else if (paddr == `REG_LINK_EVT) prdata = {24'h0, eventArg};
      else if (paddr == `REG_UART_CFG) prdata = {6'h0, framing, baud};
      else if (paddr == `REG_TIMEOUT) prdata = {24'h0, timeoutSec};
      else if (paddr == `REG_RX_DATA) prdata = {24'h0, lastRx};
      else prdata = 32'h0000_0000;
    end
  end

  // Link acceptance and transparent entry
  wire firstLink  = (linkCount == 4'h0);
  wire roleOk     = ~forceMast | peerRoleSwitchOk;         // see RQ11
  wire moreOk     = firstLink | (forceMast & ~transparent); // see RQ13
  wire takeLink   = ready & (state == ST_IDLE) & peerConnect & roleOk & moreOk;
  wire goTransp   = takeLink & firstLink & ~cmdMode;       // see RQ4 RQ7 RQ12

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_LOAD;
      loadCnt     <= 16'h0000;
      peerIdx     <= 2'h0;
      tries       <= 2'h0;
      onDemand    <= 1'b0;
      demandIdx   <= 2'h0;
      ready       <= 1'b0;
      transparent <= 1'b0;
      isMaster    <= 1'b0;
      linkCount   <= 4'h0;
      acceptLink  <= 1'b0;
      rejectLink  <= 1'b0;
      dialReq     <= 1'b0;
      dialIndex   <= 2'h0;
      eventValid  <= 1'b0;
      eventCode   <= 4'h0;
      eventArg    <= 8'h00;
      connectable     <= 1'b0;
      discoverable    <= 1'b0;
      limitedDiscover <= 1'b0;
    end else begin
      acceptLink <= 1'b0;
      rejectLink <= 1'b0;
      dialReq    <= 1'b0;
      eventValid <= 1'b0;
      if (wrCtrl && pwdata[0]) linkCount <= 4'h0;
      case (state)
        ST_LOAD: begin
          // Host is served only once the stored set has been applied
          if (loadCnt == LOAD_CYCLES[15:0]) begin          // see RQ2
            connectable     <= param[`P_PAGE_SCAN];        // see RQ3 RQ22
            discoverable    <= param[`P_INQ_LO];
            limitedDiscover <= param[`P_INQ_HI];
            ready      <= 1'b1;
            if (filter != `FILT_NONE) begin
              eventValid <= 1'b1;
              eventCode  <= EV_BOOT;
              eventArg   <= portMask;                      // see RQ21
            end
            peerIdx <= 2'h0;
            tries   <= 2'h0;
            if (!cmdMode && defCount != 2'h0) state <= ST_DIAL; // see RQ5 RQ6
            else state <= ST_IDLE;
          end else begin
            loadCnt <= loadCnt + 16'h0001;
          end
        end
        ST_DIAL: begin
          dialReq   <= 1'b1;
          dialIndex <= onDemand ? demandIdx : peerIdx;
          tries     <= tries + 2'h1;
          state     <= ST_WAIT;
        end
        ST_WAIT: begin
          if (dialDone) begin
            if (filter != `FILT_NONE) begin                // see RQ15
              eventValid <= 1'b1;
              eventCode  <= EV_LINK_STAT;                  // see RQ5
              eventArg   <= {5'h0, dialOk, dialIndex};
            end
            if (dialOk) linkCount <= linkCount + 4'h1;
            if (onDemand) begin
              onDemand <= 1'b0;
              state    <= ST_IDLE;
            end else if (!dialOk && tries != `DIAL_TRIES) begin
              state <= ST_DIAL;
            end else if (peerIdx + 2'h1 < defCount) begin
              peerIdx <= peerIdx + 2'h1;
              tries   <= 2'h0;
              state   <= ST_DIAL;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          if (onDemand) begin
            tries <= `DIAL_TRIES - 2'h1;
            state <= ST_DIAL;
          end
          if (peerConnect) begin
            acceptLink <= takeLink;
            rejectLink <= ~takeLink;
            if (takeLink) begin
              linkCount <= linkCount + 4'h1;
              if (forceMast) isMaster <= 1'b1;
              if (filter != `FILT_NONE) begin
                eventValid <= 1'b1;
                eventCode  <= EV_PORT_CONN;                // see RQ4
                eventArg   <= peerPort;
              end
            end
          end else if (phyChange && filter == `FILT_ALL) begin
            eventValid <= 1'b1;
            eventCode  <= EV_PHY;                          // see RQ15
            eventArg   <= 8'h00;
          end
        end
      endcase
      // After the case, so a new request beats the clear in the wait state
      if (wrPeer && pwdata[1:0] < 2'd3) begin              // see RQ14
        onDemand  <= 1'b1;
        demandIdx <= pwdata[1:0];
      end
      // Break exit wins; multipoint also drops transparent
      if (breakEdge || (transparent && linkCount > 4'h1)) transparent <= 1'b0; // see RQ9 RQ10
      else if (goTransp) transparent <= 1'b1;              // see RQ9
      else if (wrCtrl && pwdata[1] && linkCount == 4'h1) transparent <= 1'b1;
    end
  end

  // Received bytes: raw to link or command stream
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      linkTxValid   <= 1'b0;
      linkTxByte    <= 8'h00;
      cmdValid      <= 1'b0;
      cmdByte       <= 8'h00;
      cmdFrameStart <= 1'b0;
      cmdFrameEnd   <= 1'b0;
      lastRx        <= 8'h00;
    end else begin
      linkTxValid   <= rxValid & ready & transparent;      // see RQ8
      cmdValid      <= rxValid & ready & ~transparent;
      cmdFrameStart <= rxValid & ready & ~transparent & (rxByte == `BYTE_STX); // see RQ23
      cmdFrameEnd   <= rxValid & ready & ~transparent & (rxByte == `BYTE_ETX); // see RQ23
      if (rxValid) begin
        linkTxByte <= rxByte;
        cmdByte    <= rxByte;
        lastRx     <= rxByte;
      end
    end
  end

endmodule // serial_mode_ctrl
`default_nettype wire

// >>> hdl/mode_ctrl_map.vh
// Register map, stored-parameter defaults and timing counts of the mode controller.
// Assumes inclusion by the design file, the monitor and the bench; the guard keeps repeats harmless.
`ifndef MODE_CTRL_MAP_VH
`define MODE_CTRL_MAP_VH

// APB word offsets (byte addresses)
`define REG_CTRL        12'h000
`define REG_PARAM       12'h004
`define REG_POLICY      12'h008
`define REG_PEER_CMD    12'h00C
`define REG_STATUS      12'h010
`define REG_LINK_EVT    12'h014
`define REG_UART_CFG    12'h018
`define REG_TIMEOUT     12'h01C
`define REG_RX_DATA     12'h020

// Parameter word fields
`define P_CMD_MODE      0
`define P_FORCE_MASTER  1
`define P_FILTER_LO     2
`define P_FILTER_HI     3
`define P_DEFCNT_LO     4
`define P_DEFCNT_HI     5
`define P_PAGE_SCAN     6
`define P_INQ_LO        7
`define P_INQ_HI        8
`define P_PORTS_LO      16
`define P_PORTS_HI      23

// Stored defaults
`define PARAM_RESET     32'h0001_00C4
`define POLICY_RESET    4'hF
`define BAUD_RESET      24'h00_2580
`define FRAMING_RESET   2'h0
`define TIMEOUT_S_RESET 8'h14

// Event filter levels
`define FILT_NONE       2'h0
`define FILT_STD        2'h1
`define FILT_ALL        2'h2

// Framing bytes outside transparent mode
`define BYTE_STX        8'h02
`define BYTE_ETX        8'h03

// Dial attempts per stored peer
`define DIAL_TRIES      2'h3

// Timing
`define CLK_HZ          200000000
`define PWR_RESET_MS    2
`define PWR_RESET_CYC   ((`CLK_HZ / 1000) * `PWR_RESET_MS)

`endif

// >>> sim/mode_ctrl_monitor.sv
// Port-level checker for the serial mode controller.
// Assumes one clock, async active-low reset, bound to serial_mode_ctrl.
`timescale 1ns/1ps
`default_nettype none
`include "mode_ctrl_map.vh"
module mode_ctrl_monitor #(
  parameter int LOAD_CYCLES = 16
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       uartRx,
  input wire logic       rxValid,
  input wire logic [7:0] rxByte,
  input wire logic       linkTxValid,
  input wire logic [7:0] linkTxByte,
  input wire logic       cmdValid,
  input wire logic [7:0] cmdByte,
  input wire logic       cmdFrameStart,
  input wire logic       cmdFrameEnd,
  input wire logic       peerConnect,
  input wire logic [7:0] peerPort,
  input wire logic       acceptLink,
  input wire logic       rejectLink,
  input wire logic       dialReq,
  input wire logic [1:0] dialIndex,
  input wire logic       dialDone,
  input wire logic       phyChange,
  input wire logic       eventValid,
  input wire logic [3:0] eventCode,
  input wire logic [7:0] eventArg,
  input wire logic       ready,
  input wire logic       transparent
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  int bootCnt;
  // Freezes at ready, so a late ready shows as an overrun
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      bootCnt <= 0;
    else if (!ready && bootCnt < 1000)
      bootCnt <= bootCnt + 1;
  end
  a_boot_hold: assert property (bootCnt <= LOAD_CYCLES |-> !ready)
    else $error("ready before load");
  a_boot_done: assert property (bootCnt > LOAD_CYCLES + 1 |-> ready)
    else $error("ready late");
  a_pass_through: assert property (transparent && rxValid |=>
    linkTxValid && !cmdValid && linkTxByte == $past(rxByte)) else $error("not forwarded");
  a_cmd_route: assert property (ready && !transparent && rxValid |=>
    cmdValid && !linkTxValid && cmdByte == $past(rxByte)) else $error("not parsed");
  a_frame_flags: assert property (cmdValid |->
    cmdFrameStart == (cmdByte == `BYTE_STX) && cmdFrameEnd == (cmdByte == `BYTE_ETX))
    else $error("frame flag wrong");
  a_link_answer: assert property (ready && !transparent && peerConnect |=>
    acceptLink != rejectLink) else $error("no link answer");
  a_busy_reject: assert property (transparent && peerConnect |=> !acceptLink)
    else $error("link taken in transparent");
  a_port_event: assert property (eventValid && eventCode == 4'h1 |->
    acceptLink && eventArg == $past(peerPort)) else $error("port event wrong");
  a_break_only: assert property ($fell(transparent) |-> !$past(uartRx, 4))
    else $error("left transparent without break");
  a_dial_range: assert property (dialReq |-> dialIndex != 2'h3)
    else $error("dial index out of range");
  a_dial_event: assert property (eventValid && eventCode == 4'h2 |-> $past(dialDone))
    else $error("status event without result");
  a_phy_event: assert property (eventValid && eventCode == 4'h3 |-> $past(phyChange))
    else $error("phy event without change");
  c_transparent: cover property ($rose(transparent));
  c_reject: cover property (rejectLink);
  c_dial: cover property (dialReq);
  c_phy: cover property (eventValid && eventCode == 4'h3);
endmodule // mode_ctrl_monitor
bind serial_mode_ctrl mode_ctrl_monitor #(.LOAD_CYCLES(LOAD_CYCLES)) i_mode_ctrl_monitor (.*);
`default_nettype wire

// >>> sim/host_uart_model.sv
// Host side of the UART: byte strobes from its UART core and the raw rx line.
// Assumes the caller enters its tasks just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_uart_model (
  input  wire logic       core_clk,
  output var  logic       uartRx,
  output var  logic       rxValid,
  output var  logic [7:0] rxByte
);
  initial begin
    uartRx = 1'b1;
    rxValid = 1'b0;
    rxByte = 8'h00;
  end
  // Idle byte lines carry the inverse, never a stale copy
  task automatic send(input logic [7:0] b);
    @(posedge core_clk);
    rxValid <= 1'b1;
    rxByte <= b;
    @(posedge core_clk);
    rxValid <= 1'b0;
    rxByte <= ~b;
  endtask
  task automatic lo(input int n);
    @(posedge core_clk);
    uartRx <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic hi();
    @(posedge core_clk);
    uartRx <= 1'b1;
  endtask
endmodule // host_uart_model
`default_nettype wire

// >>> sim/serial_module_mode_control_tb.sv
// Self-checking bench for the serial mode controller.
// Assumes the map header on the include path and the host model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "mode_ctrl_map.vh"
module serial_module_mode_control_tb;
  localparam int ACC = 0, REJ = 1, TX = 2, CMD = 3, STX = 4, ETX = 5, DIAL = 6, EVT = 7;
  logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic peerConnect = 1'b0, peerRoleSwitchOk = 1'b0, phyChange = 1'b0;
  logic dialDone = 1'b0, dialOk = 1'b0, okSet = 1'b0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, r;
  logic [7:0] peerPort = 8'h00, txB, evA;
  logic [7:0] pkt [3] = '{8'h02, 8'h41, 8'h03};
  logic [3:0] evC;
  logic [1:0] dIdx;
  int cnt [8];
  int errors = 0, nChecks = 0;
  wire pready, pslverr, uartRx, rxValid, linkTxValid, cmdValid, cmdFrameStart, cmdFrameEnd;
  wire acceptLink, rejectLink, dialReq, eventValid, connectable, discoverable;
  wire limitedDiscover, ready, transparent, isMaster;
  wire [31:0] prdata;
  wire [7:0] rxByte, linkTxByte, cmdByte, eventArg;
  wire [3:0] eventCode;
  wire [1:0] dialIndex;
  serial_mode_ctrl #(.LOAD_CYCLES(16), .BREAK_BITS(11)) i_serial_mode_ctrl (.*);
  host_uart_model i_host_uart_model (.*);
  always #2.5 core_clk = ~core_clk;
  // Radio side answers each dial one cycle later
  always @(posedge core_clk) begin
    dialDone <= dialReq;
    dialOk <= okSet;
  end
  always @(posedge core_clk) begin
    if (acceptLink === 1'b1) cnt[ACC]++;
    if (rejectLink === 1'b1) cnt[REJ]++;
    if (linkTxValid === 1'b1) begin
      cnt[TX]++;
      txB = linkTxByte;
    end
    if (cmdValid === 1'b1) begin
      cnt[CMD]++;
      cnt[STX] += int'(cmdFrameStart);
      cnt[ETX] += int'(cmdFrameEnd);
    end
    if (dialReq === 1'b1) begin
      cnt[DIAL]++;
      dIdx = dialIndex;
    end
    if (eventValid === 1'b1) begin
      cnt[EVT]++;
      evC = eventCode;
      evA = eventArg;
    end
  end
  task automatic chk(input logic [127:0] s, input logic [127:0] x);
    nChecks++;
    if (s !== x) begin
      errors++;
      $display("[FAIL] %0t seen %h want %h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(k, 1);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, x);
  endtask
  task automatic reboot(input logic [31:0] p);
    int k;
    rst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    // Lands while the boot load still runs, so the load applies it
    if (p !== `PARAM_RESET) wr(`REG_PARAM, p);
    for (k = 0; k < 100 && ready !== 1'b1; k++) @(posedge core_clk);
    chk(ready, 1'b1);
  endtask
  task automatic conn(input logic ok, input logic [7:0] pt);
    @(posedge core_clk);
    peerConnect <= 1'b1;
    peerRoleSwitchOk <= ok;
    peerPort <= pt;
    @(posedge core_clk);
    peerConnect <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #300_000;
    errors++;
    close_out();
  end
  initial begin
    reboot(`PARAM_RESET);
    rd(`REG_PARAM, 32'h0001_00C4);
    rd(`REG_POLICY, 32'h0000_000F);
    rd(`REG_UART_CFG, 32'h0000_2580);
    rd(`REG_TIMEOUT, 32'h0000_0014);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk({r, e}, 33'h0_0000_0001);
    chk({connectable, discoverable, limitedDiscover}, 3'b110);
    chk(cnt[DIAL], 0);
    // Fast line so one frame is 1100 cycles
    wr(`REG_UART_CFG, 32'h001E_8480);
    cnt = '{default: 0};
    conn(1'b1, 8'h05);
    chk({cnt[ACC], evC, evA, transparent}, {32'd1, 4'h1, 8'h05, 1'b1});
    i_host_uart_model.send(`BYTE_STX);
    repeat (3) @(posedge core_clk);
    chk({cnt[TX], txB, cnt[CMD]}, {32'd1, 8'h02, 32'd0});
    i_host_uart_model.lo(900);
    chk(transparent, 1'b1);
    i_host_uart_model.lo(400);
    chk(transparent, 1'b0);
    i_host_uart_model.hi();
    foreach (pkt[i]) i_host_uart_model.send(pkt[i]);
    repeat (3) @(posedge core_clk);
    chk({cnt[CMD], cnt[STX], cnt[ETX], cnt[TX]}, {32'd3, 32'd1, 32'd1, 32'd1});
    // Two stored peers in automatic mode, every dial failing
    cnt = '{default: 0};
    reboot(32'h0001_00E4);
    repeat (40) @(posedge core_clk);
    chk({cnt[DIAL], dIdx, evC, evA}, {32'd6, 2'h1, 4'h2, 8'h01});
    chk(cnt[EVT], 7);
    // Same stored peers in command mode are skipped
    cnt = '{default: 0};
    reboot(32'h0001_00E5);
    repeat (10) @(posedge core_clk);
    chk(cnt[DIAL], 0);
    cnt = '{default: 0};
    conn(1'b1, 8'h02);
    chk({cnt[ACC], transparent}, {32'd1, 1'b0});
    okSet <= 1'b1;
    wr(`REG_PEER_CMD, 32'h0000_0002);
    repeat (20) @(posedge core_clk);
    chk({cnt[DIAL], dIdx, evC, evA}, {32'd1, 2'h2, 4'h2, 8'h06});
    okSet <= 1'b0;
    cnt = '{default: 0};
    wr(`REG_PEER_CMD, 32'h0000_0001);
    repeat (40) @(posedge core_clk);
    chk({cnt[DIAL], evA}, {32'd1, 8'h01});
    for (int f = 0; f < 3; f++) begin
      wr(`REG_PARAM, 32'h0001_00C1 | (f << `P_FILTER_LO));
      cnt = '{default: 0};
      @(posedge core_clk);
      phyChange <= 1'b1;
      @(posedge core_clk);
      phyChange <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk(cnt[EVT], (f == 2) ? 1 : 0);
    end
    reboot(`PARAM_RESET);
    wr(`REG_PARAM, 32'h0001_00C6);
    cnt = '{default: 0};
    conn(1'b0, 8'h03);
    chk({cnt[REJ], cnt[ACC]}, {32'd1, 32'd0});
    conn(1'b1, 8'h03);
    chk({cnt[ACC], isMaster, transparent}, {32'd1, 2'b11});
    conn(1'b1, 8'h04);
    chk({cnt[REJ], transparent}, {32'd2, 1'b1});
    close_out();
  end
endmodule // serial_module_mode_control_tb
`default_nettype wire
